//--- verilog/psgc_pkg.sv
// constants and types for the protection stage group control block
package psgc_pkg;
  typedef enum logic [1:0] {PSGC_IDLE, PSGC_BLOCKED, PSGC_START, PSGC_TRIP} psgc_state_t;
  localparam int unsigned PSGC_CLK_HZ        = 20000000;
  localparam int unsigned PSGC_FORCE_MS      = 500;
  localparam int unsigned PSGC_IDLE_MIN      = 5;
  localparam longint unsigned PSGC_FORCE_CYC =
    longint'(PSGC_CLK_HZ) * PSGC_FORCE_MS / 1000;
  localparam longint unsigned PSGC_IDLE_CYC  =
    longint'(PSGC_CLK_HZ) * PSGC_IDLE_MIN * 60;
  localparam int unsigned PSGC_MAX_STAGES    = 30;
  localparam int unsigned PSGC_GROUPS        = 4;
  localparam logic [1:0] PSGC_RST_GROUP      = 2'h0;
  localparam logic [15:0] PSGC_RST_COUNT     = 16'h0000;
endpackage

//--- verilog/psgc_top.sv
// group selection, stage status, counters and test forcing for protection stages
`timescale 1ns/1ps
module psgc_top #(
  parameter int unsigned  NSTAGE    = 4,
  parameter int unsigned  NDI       = 8,
  parameter int unsigned  DLYW      = 24,
  parameter int unsigned  CNTW      = 16,
  parameter int unsigned  FORCE_CYC = 32'(psgc_pkg::PSGC_FORCE_CYC),
  parameter longint unsigned IDLE_CYC = psgc_pkg::PSGC_IDLE_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic [NDI-1:0]           digital_input_line,
  input  wire logic [4*NDI-1:0]         group_input_assignment,
  input  wire logic [1:0]               fallback_group_setting,
  input  wire logic                     group_priority_order,
  input  wire logic                     hold_previous,
  input  wire logic                     global_override_en,
  input  wire logic [1:0]               global_group_override,
  input  wire logic [NSTAGE-1:0]        stage_enable,
  input  wire logic [NSTAGE-1:0]        stage_local_ctrl,
  input  wire logic [NSTAGE-1:0]        fault_above_start,
  input  wire logic [NSTAGE-1:0]        fault_above_hyst,
  input  wire logic [NSTAGE-1:0]        block_matrix,
  input  wire logic [NSTAGE-1:0]        block_logic,
  input  wire logic [NSTAGE-1:0]        block_input,
  input  wire logic [NSTAGE-1:0]        block_builtin,
  input  wire logic [4*NSTAGE*DLYW-1:0] op_delay,
  input  wire logic                     force_flag_set,
  input  wire logic                     panel_button,
  input  wire logic [NSTAGE-1:0]        force_start_cmd,
  input  wire logic [NSTAGE-1:0]        force_trip_cmd,
  output logic      [1:0]               active_group,
  output logic      [2*NSTAGE-1:0]      stage_group,
  output logic      [2*NSTAGE-1:0]      stage_state,
  output logic      [NSTAGE-1:0]        start_out,
  output logic      [NSTAGE-1:0]        trip_out,
  output logic      [NSTAGE*CNTW-1:0]   start_count,
  output logic      [NSTAGE*CNTW-1:0]   trip_count,
  output logic                          force_flag,
  output logic                          output_force_en,
  output logic      [NSTAGE-1:0]        stage_over_limit
);
  typedef struct packed {
    logic [NDI-1:0]            di_s1;
    logic [NDI-1:0]            di_s2;
    logic                      btn_s1;
    logic                      btn_s2;
    logic [1:0]                grp;
    logic                      flag;
    logic [39:0]               idle_cnt;
    logic [NSTAGE-1:0]         fault;
    logic [NSTAGE-1:0][1:0]    st;
    logic [NSTAGE-1:0][DLYW-1:0] dly;
    logic [NSTAGE-1:0][31:0]   fcnt;
    logic [NSTAGE-1:0]         ftrip;
    logic [NSTAGE-1:0][CNTW-1:0] scnt;
    logic [NSTAGE-1:0][CNTW-1:0] tcnt;
  } psgc_state_reg_t;

  psgc_state_reg_t s_reg;
  psgc_state_reg_t s_next;
  logic [3:0]      grp_req;
  logic [1:0]      grp_pick;
  logic [1:0]      ovr_grp;
  logic [7:0]      en_sum;

  // each group ors the digital inputs routed to it
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      grp_req[g] = |(s_reg.di_s2 & group_input_assignment[g*NDI +: NDI]);
    end
  end

  // ascending picks lowest set group, descending highest
  // the last hit of the scan wins, so ascending order scans downward
  always_comb begin
    grp_pick = 2'h0;
    if (group_priority_order) begin
      for (int g = 3; g >= 0; g--) begin
        if (grp_req[g]) begin
          grp_pick = 2'(g);
        end
      end
    end else begin
      for (int g = 0; g < 4; g++) begin
        if (grp_req[g]) begin
          grp_pick = 2'(g);
        end
      end
    end
  end

  // stages beyond the enabled-stage budget are held idle
  always_comb begin
    en_sum = 8'h00;
    for (int i = 0; i < NSTAGE; i++) begin
      stage_over_limit[i] = stage_enable[i] && (en_sum >= 8'(psgc_pkg::PSGC_MAX_STAGES));
      en_sum = en_sum + 8'(stage_enable[i]);
    end
  end

  assign ovr_grp = global_override_en ? global_group_override : s_reg.grp;

  always_comb begin
    logic blk;
    logic [DLYW-1:0] lim;
    blk = 1'b0;
    lim = '0;
    s_next = s_reg;
    s_next.di_s1 = digital_input_line;
    s_next.di_s2 = s_reg.di_s1;
    s_next.btn_s1 = panel_button;
    s_next.btn_s2 = s_reg.btn_s1;
    if (|grp_req) begin
      s_next.grp = grp_pick;
    end else if (!hold_previous) begin
      s_next.grp = fallback_group_setting;
    end // otherwise the last group stays
    // idle counter restarts on any button press, ends the flag
    if (force_flag_set) begin
      s_next.flag = 1'b1;
      s_next.idle_cnt = '0;
    end else if (s_reg.flag) begin
      if (s_reg.btn_s2) begin
        s_next.idle_cnt = '0;
      end else if (s_reg.idle_cnt >= 40'(IDLE_CYC - 1)) begin
        s_next.flag = 1'b0;
        s_next.idle_cnt = '0;
      end else begin
        s_next.idle_cnt = s_reg.idle_cnt + 40'h1;
      end
    end
    for (int i = 0; i < NSTAGE; i++) begin
      // four delay settings per stage, indexed by its group
      lim = op_delay[(i*4 + int'(stage_group[2*i +: 2]))*DLYW +: DLYW];
      blk = block_matrix[i] | block_logic[i] | block_input[i] | block_builtin[i];
      // fault latches at start level, drops below hysteresis level
      s_next.fault[i] = fault_above_start[i] | (s_reg.fault[i] & fault_above_hyst[i]);
      // forcing holds the stage for a fixed window, no fault needed
      if (s_reg.fcnt[i] != 32'h0) begin
        s_next.fcnt[i] = s_reg.fcnt[i] - 32'h1;
      end
      if (s_reg.flag && (force_start_cmd[i] || force_trip_cmd[i]) && s_reg.fcnt[i] == 32'h0) begin
        s_next.fcnt[i] = FORCE_CYC;
        s_next.ftrip[i] = force_trip_cmd[i];
        if (force_trip_cmd[i]) begin
          s_next.tcnt[i] = s_reg.tcnt[i] + CNTW'(1);
        end else begin
          s_next.scnt[i] = s_reg.scnt[i] + CNTW'(1);
        end
      end
      if (!stage_enable[i] || stage_over_limit[i] || !s_next.fault[i]) begin
        s_next.st[i] = 2'(psgc_pkg::PSGC_IDLE); // fault gone, no trip
        s_next.dly[i] = '0;
      end else begin
        unique case (psgc_pkg::psgc_state_t'(s_reg.st[i]))
          psgc_pkg::PSGC_IDLE, psgc_pkg::PSGC_BLOCKED: begin
            if (blk) begin
              s_next.st[i] = 2'(psgc_pkg::PSGC_BLOCKED); // count frozen
            end else begin
              s_next.st[i] = 2'(psgc_pkg::PSGC_START);
              if (s_reg.st[i] == 2'(psgc_pkg::PSGC_IDLE)) begin
                s_next.scnt[i] = s_reg.scnt[i] + CNTW'(1);
              end
            end
          end
          psgc_pkg::PSGC_START: begin
            if (blk) begin
              s_next.st[i] = 2'(psgc_pkg::PSGC_BLOCKED);
            end else if (s_reg.dly[i] + DLYW'(1) >= lim) begin
              s_next.st[i] = 2'(psgc_pkg::PSGC_TRIP);
              s_next.tcnt[i] = s_reg.tcnt[i] + CNTW'(1);
            end else begin
              s_next.dly[i] = s_reg.dly[i] + DLYW'(1);
            end
          end
          psgc_pkg::PSGC_TRIP: begin
            s_next.st[i] = 2'(psgc_pkg::PSGC_TRIP); // blocking ignored
          end
        endcase
      end
    end
  end

  // reset is the reboot: idle, group PSGC_RST_GROUP (group 0), zero counters
  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.grp <= psgc_pkg::PSGC_RST_GROUP;
    end else begin
      s_reg <= s_next;
    end
  end

  // override reaches only stages without local group control
  generate
    for (genvar i = 0; i < NSTAGE; i++) begin : g_stage
      logic forced;
      assign forced = s_reg.fcnt[i] != 32'h0;
      assign stage_group[2*i +: 2] = stage_local_ctrl[i] ? s_reg.grp : ovr_grp;
      assign stage_state[2*i +: 2] = forced ?
        (s_reg.ftrip[i] ? 2'(psgc_pkg::PSGC_TRIP) : 2'(psgc_pkg::PSGC_START)) : s_reg.st[i];
      // start follows the registered stage state (start or trip) or an active forcing window
      assign start_out[i] = s_reg.st[i] == 2'(psgc_pkg::PSGC_START) ||
                            s_reg.st[i] == 2'(psgc_pkg::PSGC_TRIP) || forced;
      assign trip_out[i] = s_reg.st[i] == 2'(psgc_pkg::PSGC_TRIP) || (forced && s_reg.ftrip[i]);
      assign start_count[i*CNTW +: CNTW] = s_reg.scnt[i];
      assign trip_count[i*CNTW +: CNTW] = s_reg.tcnt[i];
    end
  endgenerate

  assign active_group = s_reg.grp;
  assign force_flag = s_reg.flag;
  assign output_force_en = s_reg.flag;

  a_group_fallback: assert property (@(posedge clk) disable iff (reset)
    (grp_req == 4'h0 && !hold_previous) |=> active_group == $past(fallback_group_setting))
    else $error("fallback group not selected");
  a_group_follow: assert property (@(posedge clk) disable iff (reset)
    (|grp_req) |=> active_group == $past(grp_pick))
    else $error("active group does not follow inputs");
  a_group_hold: assert property (@(posedge clk) disable iff (reset)
    (grp_req == 4'h0 && hold_previous) |=> $stable(active_group))
    else $error("held group changed");
  a_prio_low: assert property (@(posedge clk) disable iff (reset)
    (group_priority_order && grp_req[0]) |=> active_group == 2'h0)
    else $error("ascending priority broken");
  a_prio_high: assert property (@(posedge clk) disable iff (reset)
    (!group_priority_order && grp_req[3]) |=> active_group == 2'h3)
    else $error("descending priority broken");
  a_trip_stays: assert property (@(posedge clk) disable iff (reset)
    (s_reg.st[0] == 2'(psgc_pkg::PSGC_TRIP) && stage_enable[0] && !stage_over_limit[0] &&
     fault_above_hyst[0]) |=> trip_out[0])
    else $error("trip dropped while fault held");
  a_block_freeze: assert property (@(posedge clk) disable iff (reset)
    (s_reg.st[0] != 2'(psgc_pkg::PSGC_TRIP) && (block_matrix[0] | block_builtin[0])) |=>
    !trip_out[0] || s_reg.fcnt[0] != 32'h0)
    else $error("blocked stage tripped");
  a_trip_count: assert property (@(posedge clk) disable iff (reset)
    ($rose(s_reg.st[0] == 2'(psgc_pkg::PSGC_TRIP))) |-> trip_count[CNTW-1:0] ==
    $past(trip_count[CNTW-1:0]) + CNTW'(1))
    else $error("trip not counted");
  a_flag_out: assert property (@(posedge clk) disable iff (reset)
    force_flag |-> output_force_en)
    else $error("output forcing not enabled");
  a_start_fault: assert property (@(posedge clk) disable iff (reset)
    (fault_above_start[0] && stage_enable[0] && !stage_over_limit[0] && !block_matrix[0] &&
     !block_logic[0] && !block_input[0] && !block_builtin[0] &&
     s_reg.st[0] == 2'(psgc_pkg::PSGC_IDLE)) |=> start_out[0])
    else $error("start not raised on fault");

  c_trip: cover property (@(posedge clk) disable iff (reset) $rose(trip_out[0]));
  c_block: cover property (@(posedge clk) disable iff (reset)
    s_reg.st[0] == 2'(psgc_pkg::PSGC_BLOCKED));
  c_force: cover property (@(posedge clk) disable iff (reset) s_reg.fcnt[0] != 32'h0);
  c_group3: cover property (@(posedge clk) disable iff (reset) active_group == 2'h3);
  c_force_trip: cover property (@(posedge clk) disable iff (reset)
    trip_out[0] && s_reg.fcnt[0] != 32'h0);

  // reset is the reboot, so nothing may survive it
  a_count_reset: assert property (@(posedge clk)
    reset |=> start_count == '0 && trip_count == '0)
    else $error("counters not cleared by reset");
  a_group_reset: assert property (@(posedge clk)
    reset |=> active_group == psgc_pkg::PSGC_RST_GROUP)
    else $error("group not restored by reset");
  a_flag_set: assert property (@(posedge clk) disable iff (reset)
    force_flag_set |=> force_flag)
    else $error("forcing flag not set");
  a_flag_timeout: assert property (@(posedge clk) disable iff (reset)
    (s_reg.flag && !force_flag_set && !s_reg.btn_s2 &&
     s_reg.idle_cnt >= 40'(IDLE_CYC - 1)) |=> !force_flag)
    else $error("forcing flag outlived idle time");

  // per-stage checks, so every stage is watched and not only the first
  generate
    for (genvar i = 0; i < NSTAGE; i++) begin : g_check
      logic any_blk;
      logic run_ok;
      assign any_blk = block_matrix[i] | block_logic[i] | block_input[i] | block_builtin[i];
      assign run_ok = stage_enable[i] && !stage_over_limit[i] && s_next.fault[i];

      a_limit_idle: assert property (@(posedge clk) disable iff (reset)
        stage_over_limit[i] |=> s_reg.st[i] == 2'(psgc_pkg::PSGC_IDLE))
        else $error("stage over limit not idle");
      a_disabled_idle: assert property (@(posedge clk) disable iff (reset)
        !stage_enable[i] |=> s_reg.st[i] == 2'(psgc_pkg::PSGC_IDLE))
        else $error("disabled stage not idle");
      a_fault_hold: assert property (@(posedge clk) disable iff (reset)
        (s_reg.fault[i] && fault_above_hyst[i]) |=> s_reg.fault[i])
        else $error("fault dropped above hysteresis");
      a_fault_drop: assert property (@(posedge clk) disable iff (reset)
        (!fault_above_start[i] && !fault_above_hyst[i]) |=> !s_reg.fault[i])
        else $error("fault kept below hysteresis");
      a_block_enter: assert property (@(posedge clk) disable iff (reset)
        (s_reg.st[i] == 2'(psgc_pkg::PSGC_START) && any_blk && run_ok) |=>
        s_reg.st[i] == 2'(psgc_pkg::PSGC_BLOCKED))
        else $error("blocked stage kept counting");
      a_dly_frozen: assert property (@(posedge clk) disable iff (reset)
        (s_reg.st[i] == 2'(psgc_pkg::PSGC_BLOCKED) && any_blk && run_ok) |=>
        $stable(s_reg.dly[i]))
        else $error("delay moved while blocked");
      a_trip_hold: assert property (@(posedge clk) disable iff (reset)
        (s_reg.st[i] == 2'(psgc_pkg::PSGC_TRIP) && run_ok) |=>
        s_reg.st[i] == 2'(psgc_pkg::PSGC_TRIP))
        else $error("trip left while fault held");
      a_start_count: assert property (@(posedge clk) disable iff (reset)
        (s_reg.st[i] == 2'(psgc_pkg::PSGC_IDLE) && !any_blk && run_ok) |=>
        s_reg.scnt[i] == $past(s_reg.scnt[i]) + CNTW'(1))
        else $error("start not counted");
      a_trip_start: assert property (@(posedge clk) disable iff (reset)
        trip_out[i] |-> start_out[i])
        else $error("trip without start");
      a_force_refused: assert property (@(posedge clk) disable iff (reset)
        (!s_reg.flag && s_reg.fcnt[i] == 32'h0) |=> s_reg.fcnt[i] == 32'h0)
        else $error("forcing taken without flag");
      a_force_len: assert property (@(posedge clk) disable iff (reset)
        $rose(s_reg.fcnt[i] != 32'h0) |-> s_reg.fcnt[i] == FORCE_CYC)
        else $error("forcing window length wrong");
      a_force_step: assert property (@(posedge clk) disable iff (reset)
        (s_reg.fcnt[i] != 32'h0) |=> s_reg.fcnt[i] == $past(s_reg.fcnt[i]) - 32'h1)
        else $error("forcing window restarted early");
      a_force_state: assert property (@(posedge clk) disable iff (reset)
        (s_reg.fcnt[i] != 32'h0) |-> stage_state[2*i +: 2] ==
        (s_reg.ftrip[i] ? 2'(psgc_pkg::PSGC_TRIP) : 2'(psgc_pkg::PSGC_START)))
        else $error("forced state not shown");
      a_group_local: assert property (@(posedge clk) disable iff (reset)
        stage_local_ctrl[i] |-> stage_group[2*i +: 2] == active_group)
        else $error("local stage left active group");
      a_group_global: assert property (@(posedge clk) disable iff (reset)
        (!stage_local_ctrl[i] && global_override_en) |->
        stage_group[2*i +: 2] == global_group_override)
        else $error("override not applied");
    end
  endgenerate
endmodule

//--- sim/psgc_far_model.sv
// far-side model: digital input contacts and the front panel push-button
`timescale 1ns/1ps
module psgc_far_model #(
  parameter int unsigned NDI = 8
) (
  input  wire logic           clk,
  output logic      [NDI-1:0] digital_input_line,
  output logic                panel_button
);
  initial begin
    digital_input_line = '0;
    panel_button       = 1'b0;
  end
  // contacts move just after an edge; pins are synchronised inside, so any phase would do
  task automatic set_inputs(input logic [NDI-1:0] v);
    @(posedge clk);
    digital_input_line <= v;
  endtask
  // a press is held four cycles so the two-flop synchroniser cannot miss it
  task automatic press();
    @(posedge clk);
    panel_button <= 1'b1;
    repeat (4) @(posedge clk);
    panel_button <= 1'b0;
  endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench for group selection, stage status, counters and forcing
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned NS = 4;
  localparam int unsigned ND = 8;
  localparam int unsigned FC = 20;
  localparam int unsigned IC = 50;
  typedef struct {int k; logic [15:0] v;} psgc_note_t;
  logic               clk, reset, prio, hold, ov_en, ff_set;
  logic [1:0]         fb, ov_grp, act, g;
  logic [ND-1:0]      di;
  logic               btn, ffl, ofe;
  logic [4*ND-1:0]    asg;
  logic [NS-1:0]      en, lc, f_st, f_hy, fs, ft, so, to, ovl;
  logic [NS-1:0]      blk [4];
  logic [4*NS*24-1:0] dly;
  logic [2*NS-1:0]    sgrp, sst;
  logic [NS*16-1:0]   sc, tc;
  int                 error_cnt = 0, num_checks = 0, seed = 32'h6deb, d, sc_e, tc_e;
  psgc_note_t         q[$];
  string              nm [8] = '{"active_group", "stage_state", "trip_out", "start_count",
                                 "trip_count", "force_flags", "stage_group", "start_out"};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  psgc_top #(.NSTAGE(NS), .NDI(ND), .FORCE_CYC(FC), .IDLE_CYC(IC)) dut_u (
    .clk(clk), .reset(reset), .digital_input_line(di), .group_input_assignment(asg),
    .fallback_group_setting(fb), .group_priority_order(prio), .hold_previous(hold),
    .global_override_en(ov_en), .global_group_override(ov_grp), .stage_enable(en),
    .stage_local_ctrl(lc), .fault_above_start(f_st), .fault_above_hyst(f_hy),
    .block_matrix(blk[0]), .block_logic(blk[1]), .block_input(blk[2]),
    .block_builtin(blk[3]), .op_delay(dly), .force_flag_set(ff_set), .panel_button(btn),
    .force_start_cmd(fs), .force_trip_cmd(ft), .active_group(act), .stage_group(sgrp),
    .stage_state(sst), .start_out(so), .trip_out(to), .start_count(sc), .trip_count(tc),
    .force_flag(ffl), .output_force_en(ofe), .stage_over_limit(ovl));
  psgc_far_model #(.NDI(ND)) far (.clk(clk), .digital_input_line(di), .panel_button(btn));
  function automatic logic [15:0] obs(int k);
    case (k)
      0: return {14'h0, act};
      1: return {14'h0, sst[1:0]};
      2: return {15'h0, to[0]};
      3: return sc[15:0];
      4: return tc[15:0];
      5: return {14'h0, ofe, ffl};
      6: return {12'h0, sgrp[3:0]};
      default: return {15'h0, so[0]};
    endcase
  endfunction
  function automatic logic [1:0] grp(logic [3:0] v, logic [1:0] last);
    if (v == 4'h0) return hold ? last : fb;
    for (int i = 0; i < 4; i++)
      if (v[prio ? i : 3 - i]) return prio ? 2'(i) : 2'(3 - i);
    return last;
  endfunction
  task automatic chk(string n, logic [15:0] seen, logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, want, seen);
    end
  endtask
  task automatic exp(int k, logic [15:0] v);
    q.push_back('{k, v});
  endtask
  // notes are taken at the falling edge, after the rising edge's updates have landed
  always @(negedge clk) begin
    while (q.size() > 0) begin
      chk(nm[q[0].k], obs(q[0].k), q[0].v);
      void'(q.pop_front());
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_trip(int lim);
    for (int i = 0; i <= lim; i++) begin
      @(negedge clk);
      if (to[0] === 1'b1) return;
    end
    error_cnt++;
    $display("MISMATCH trip_wait expected 1 seen 0");
    end_sim();
  endtask
  initial begin
    {reset, prio, hold, ov_en, ff_set} = 5'h18;
    {fb, ov_grp, en, lc} = 12'hbff;
    {f_st, f_hy, fs, ft} = '0;
    for (int s = 0; s < 4; s++) blk[s] = '0;
    // group g is controlled by input g; the upper inputs are unassigned
    asg = 32'h0804_0201;
    // operate delay grows with the group, so a wrong group shows up as a wrong trip time
    for (int i = 0; i < 16; i++) dly[i*24+:24] = 24'(3 + 2 * (i % 4));
    tick(12);
    exp(0, 16'h0000);
    exp(3, 16'h0000);
    reset <= 1'b0;
    tick(4);
    exp(0, 16'h0002);
    far.set_inputs(8'h02);
    tick(3);
    exp(0, 16'h0001);
    far.set_inputs(8'h06);
    tick(3);
    exp(0, 16'h0001);
    prio <= 1'b0;
    tick(3);
    exp(0, 16'h0002);
    hold <= 1'b1;
    far.set_inputs(8'h00);
    tick(3);
    exp(0, 16'h0002);
    g = 2'h2;
    fb <= 2'h1;
    for (int i = 0; i < 10; i++) begin
      prio <= 1'($random(seed));
      hold <= 1'($random(seed));
      tick(1);
      // the old inputs are judged once more under the new order and hold
      g = grp(di[3:0], g);
      far.set_inputs(8'($random(seed)));
      tick(3);
      g = grp(di[3:0], g);
      exp(0, {14'h0, g});
    end
    hold <= 1'b0;
    far.set_inputs(8'h00);
    tick(3);
    d = 5;
    exp(0, 16'h0001);
    {f_st[0], f_hy[0]} <= 2'h3;
    tick(1);
    exp(7, 16'h0001);
    exp(1, 16'(psgc_pkg::PSGC_START));
    exp(3, 16'h0001);
    tick(d - 1);
    exp(2, 16'h0000);
    tick(1);
    exp(2, 16'h0001);
    exp(4, 16'h0001);
    blk[0][0] <= 1'b1;
    f_st[0] <= 1'b0;
    tick(3);
    exp(1, 16'(psgc_pkg::PSGC_TRIP));
    {f_hy[0], blk[0][0]} <= 2'h0;
    tick(3);
    exp(1, 16'(psgc_pkg::PSGC_IDLE));
    {f_st[0], f_hy[0]} <= 2'h3;
    tick(2);
    {f_st[0], f_hy[0]} <= 2'h0;
    tick(d + 2);
    exp(2, 16'h0000);
    exp(4, 16'h0001);
    sc_e = 2;
    tc_e = 1;
    for (int s = 0; s < 4; s++) begin
      {f_st[0], f_hy[0]} <= 2'h3;
      tick(2);
      blk[s][0] <= 1'b1;
      tick(3);
      exp(1, 16'(psgc_pkg::PSGC_BLOCKED));
      tick(d + 2);
      exp(2, 16'h0000);
      blk[s][0] <= 1'b0;
      wait_trip(d);
      tick(1);
      {f_st[0], f_hy[0]} <= 2'h0;
      tick(3);
      sc_e++;
      tc_e++;
      exp(3, 16'(sc_e));
      exp(4, 16'(tc_e));
    end
    ft[0] <= 1'b1;
    tick(1);
    ft[0] <= 1'b0;
    tick(2);
    exp(2, 16'h0000);
    ff_set <= 1'b1;
    tick(1);
    ff_set <= 1'b0;
    tick(1);
    exp(5, 16'h0003);
    for (int c = 0; c < 2; c++) begin
      far.press();
      {fs[0], ft[0]} <= c ? 2'h1 : 2'h2;
      tick(1);
      {fs[0], ft[0]} <= 2'h0;
      tick(1);
      exp(c ? 2 : 7, 16'h0001);
      exp(1, c ? 16'(psgc_pkg::PSGC_TRIP) : 16'(psgc_pkg::PSGC_START));
      tick(FC - 3);
      exp(c ? 2 : 7, 16'h0001);
      tick(6);
      exp(c ? 2 : 7, 16'h0000);
    end
    far.press();
    tick(40);
    exp(5, 16'h0003);
    far.press();
    tick(40);
    exp(5, 16'h0003);
    tick(30);
    exp(5, 16'h0000);
    lc <= 4'hd;
    ov_en <= 1'b1;
    tick(2);
    exp(6, 16'h000d);
    reset <= 1'b1;
    tick(1);
    reset <= 1'b0;
    exp(3, 16'h0000);
    exp(4, 16'h0000);
    tick(2);
    @(negedge clk);
    chk("stage_over_limit", {12'h0, ovl}, 16'h0000);
    end_sim();
  end
endmodule
